// *** core/scm_pkg.sv ***
package scm_pkg;
    // Command encodings; upper three bits select the parameter operations.
    localparam logic [2:0] OP_SYSTEM              = 3'h0;
    localparam logic [2:0] OP_PARAM_READ          = 3'h4;
    localparam logic [2:0] OP_PARAM_WRITE         = 3'h5;
    localparam logic [2:0] OP_PARAM_BITWISE_AND   = 3'h6;
    localparam logic [2:0] OP_PARAM_BITWISE_OR    = 3'h7;
    localparam logic [7:0] CLEAR_RESPONSE_CMD     = 8'h00;
    localparam logic [7:0] SOFT_RESET_CMD         = 8'h01;
    localparam logic [7:0] SLAVE_ADDR_CHANGE_CMD  = 8'h02;
    localparam logic [7:0] PROX_SINGLE_SHOT_CMD   = 8'h05;
    localparam logic [7:0] AMBIENT_SINGLE_SHOT_CMD = 8'h06;
    localparam logic [7:0] BOTH_SINGLE_SHOT_CMD   = 8'h07;
    localparam logic [7:0] PROX_LOOP_HALT_CMD     = 8'h09;
    localparam logic [7:0] AMBIENT_LOOP_HALT_CMD  = 8'h0a;
    localparam logic [7:0] BOTH_LOOP_HALT_CMD     = 8'h0b;
    localparam logic [7:0] PROX_LOOP_RUN_CMD      = 8'h0d;
    localparam logic [7:0] AMBIENT_LOOP_RUN_CMD   = 8'h0e;
    localparam logic [7:0] BOTH_LOOP_RUN_CMD      = 8'h0f;
    // Response codes, chip states, reset slave address and parameter count.
    localparam logic [7:0] RESPONSE_RESET         = 8'h00;
    localparam logic [7:0] INVALID_SETTING_CODE   = 8'h80;
    localparam logic [7:0] OVERFLOW_BASE_CODE     = 8'h88;
    localparam logic [7:0] CHIP_STATE_READY       = 8'h01;
    localparam logic [7:0] CHIP_STATE_SLEEP       = 8'h00;
    localparam logic [7:0] CHIP_STATE_BUSY        = 8'h02;
    localparam logic [6:0] SLAVE_ADDR_RESET       = 7'h5a;
    localparam int         PARAM_COUNT            = 32;
endpackage : scm_pkg

// *** core/scm_mailbox.sv ***
`timescale 1ns/1ps
// What this block does
// - OR command merges mailbox into parameter, echoes.
// - Clear command zeroes the response register.
// - Reset command restores sequencer state.
// - Address command changes slave address, no error.
// - Decode three single-shot measurement commands.
// - Decode three loop halt commands.
// - Decode three loop start commands.
// - No error: counter increments per completion.
// - Invalid setting loads 0x80 until cleared.
// - Proximity overflows load 0x88, 0x89, 0x8a.
// - Ambient overflows load 0x8c, 0x8d, 0x8e.
// - Single shot completion signalled by done flag.
// - Reserved codes do nothing defined.
// - Reset gives no completion; host waits 1ms.
// - Read keeps parameter, echoes; write, AND commands update parameter, echo.
// - Only command writes wake the sequencer.
module scm_mailbox #(
    parameter int PARAM_WIDTH = 8
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   clk_en,
    input  wire logic                   cmd_write,
    input  wire logic [7:0]             cmd_code,
    input  wire logic [PARAM_WIDTH-1:0] param_write_mailbox,
    input  wire logic                   meas_done,
    input  wire logic                   overflow_pin,
    input  wire logic [2:0]             overflow_chan,
    input  wire logic                   invalid_setting,
    output logic      [7:0]             response,
    output logic      [PARAM_WIDTH-1:0] param_read_mailbox,
    output logic      [6:0]             slave_address,
    output logic                        prox_loop_on,
    output logic                        ambient_loop_on,
    output logic                        prox_shot,
    output logic                        ambient_shot,
    output logic                        awake,
    output logic      [7:0]             chip_state_value,
    output logic      [7:0]             interrupt_status_value
);
    // The address command takes seven mailbox bits, so a narrower mailbox cannot serve it.
    if (PARAM_WIDTH < 7 || PARAM_WIDTH > 8) begin : g_width_check
        $error("PARAM_WIDTH must be 7 or 8");
    end

    typedef enum logic [1:0] {SCM_SLEEP, SCM_EXEC, SCM_WAIT_MEAS} scm_state_t;

    scm_state_t             state;
    logic [7:0]             cmd;
    logic [PARAM_WIDTH-1:0] params [scm_pkg::PARAM_COUNT];
    logic [1:0]             ovf_sync;
    logic                   ovf_seen;

    // Overflow arrives from the converter pins, so it is synchronised first.
    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_sync <= 2'h0;
        end else if (clk_en) begin
            ovf_sync <= {ovf_sync[0], overflow_pin};
        end
    end

    wire       ovf_rise   = ovf_sync[1] & ~ovf_seen;
    wire [2:0] op         = cmd[7:5];
    wire [4:0] index      = cmd[4:0];
    wire       is_param   = op[2];
    wire       is_sys     = (op == scm_pkg::OP_SYSTEM);
    wire       is_clear   = (cmd == scm_pkg::CLEAR_RESPONSE_CMD);
    wire       is_reset   = (cmd == scm_pkg::SOFT_RESET_CMD);
    wire       is_addr    = (cmd == scm_pkg::SLAVE_ADDR_CHANGE_CMD);
    wire       is_shot    = (cmd == scm_pkg::PROX_SINGLE_SHOT_CMD) ||
                            (cmd == scm_pkg::AMBIENT_SINGLE_SHOT_CMD) ||
                            (cmd == scm_pkg::BOTH_SINGLE_SHOT_CMD);
    wire       is_halt    = (cmd == scm_pkg::PROX_LOOP_HALT_CMD) ||
                            (cmd == scm_pkg::AMBIENT_LOOP_HALT_CMD) ||
                            (cmd == scm_pkg::BOTH_LOOP_HALT_CMD);
    wire       is_run     = (cmd == scm_pkg::PROX_LOOP_RUN_CMD) ||
                            (cmd == scm_pkg::AMBIENT_LOOP_RUN_CMD) ||
                            (cmd == scm_pkg::BOTH_LOOP_RUN_CMD);
    wire       has_error  = response[7];
    // Parameter result: read keeps, write replaces, AND and OR merge.
    wire [PARAM_WIDTH-1:0] cur = params[index];
    wire [PARAM_WIDTH-1:0] next_param =
        (op == scm_pkg::OP_PARAM_WRITE) ? param_write_mailbox :
        (op == scm_pkg::OP_PARAM_BITWISE_AND) ? (cur & param_write_mailbox) :
        (op == scm_pkg::OP_PARAM_BITWISE_OR)  ? (cur | param_write_mailbox) : cur;
    wire [7:0] count_up   = {4'h0, response[3:0] + 4'h1};
    wire [7:0] ovf_code   = scm_pkg::OVERFLOW_BASE_CODE + {5'h00, overflow_chan};

    // Command engine; a command write is the only way out of sleep.
    always_ff @(posedge clk) begin
        if (reset) begin
            state           <= SCM_SLEEP;
            cmd             <= 8'h00;
            response        <= scm_pkg::RESPONSE_RESET;
            param_read_mailbox <= '0;
            slave_address   <= scm_pkg::SLAVE_ADDR_RESET;
            prox_loop_on    <= 1'b0;
            ambient_loop_on <= 1'b0;
            prox_shot       <= 1'b0;
            ambient_shot    <= 1'b0;
            awake           <= 1'b0;
            ovf_seen        <= 1'b0;
            interrupt_status_value <= 8'h00;
            chip_state_value <= scm_pkg::CHIP_STATE_SLEEP;
        end else if (clk_en) begin
            prox_shot    <= 1'b0;
            ambient_shot <= 1'b0;
            ovf_seen     <= ovf_sync[1];
            case (state)
                SCM_SLEEP: begin
                    if (cmd_write) begin
                        cmd              <= cmd_code;
                        awake            <= 1'b1;
                        state            <= SCM_EXEC;
                        chip_state_value <= scm_pkg::CHIP_STATE_BUSY;
                    end
                end
                SCM_EXEC: begin
                    state            <= SCM_SLEEP;
                    awake            <= 1'b0;
                    chip_state_value <= scm_pkg::CHIP_STATE_READY;
                    if (is_clear) begin
                        response <= 8'h00;
                    end else if (is_reset) begin
                        // Response goes to zero rather than counting, so a reset never looks like a completion.
                        response        <= 8'h00;
                        prox_loop_on    <= 1'b0;
                        ambient_loop_on <= 1'b0;
                        slave_address   <= scm_pkg::SLAVE_ADDR_RESET;
                        interrupt_status_value <= 8'h00;
                    end else if (invalid_setting) begin
                        // An invalid setting stops the command; a latched error keeps its own code.
                        if (!has_error) begin
                            response <= scm_pkg::INVALID_SETTING_CODE;
                        end
                    end else begin
                        if (is_param) begin
                            params[index]      <= next_param;
                            param_read_mailbox <= next_param;
                        end
                        if (is_addr) begin
                            slave_address <= param_write_mailbox[6:0];
                        end
                        if (is_shot) begin
                            prox_shot    <= ~cmd[1] | cmd[0];
                            ambient_shot <= cmd[1];
                            interrupt_status_value <= 8'h00;
                            chip_state_value <= scm_pkg::CHIP_STATE_BUSY;
                            state        <= SCM_WAIT_MEAS;
                            awake        <= 1'b1;
                        end
                        if (is_halt) begin
                            prox_loop_on    <= prox_loop_on & ~cmd[0];
                            ambient_loop_on <= ambient_loop_on & ~cmd[1];
                        end
                        if (is_run) begin
                            prox_loop_on    <= prox_loop_on | cmd[0];
                            ambient_loop_on <= ambient_loop_on | cmd[1];
                        end
                        // Reserved system codes still complete quietly.
                        if (!has_error && (is_param || is_sys)) begin
                            response <= count_up;
                        end
                    end
                end
                SCM_WAIT_MEAS: begin
                    if (meas_done) begin
                        interrupt_status_value <= 8'h01;
                        chip_state_value <= scm_pkg::CHIP_STATE_READY;
                        awake <= 1'b0;
                        state <= SCM_SLEEP;
                    end
                end
                default: state <= SCM_SLEEP;
            endcase
            // Last in the process, so an overflow beats a same-cycle clear; a latched error keeps its code.
            if (ovf_rise && !has_error) begin
                response <= ovf_code;
            end
        end
    end

    // Guards on the command engine; an overflow in the same cycle is excluded where it may win.
    a_error_sticks: assert property (@(posedge clk) disable iff (reset)
        (clk_en && has_error && !(state == SCM_EXEC && (is_clear || is_reset))) |=> response[7])
        else $error("error code lost");
    a_clear_zero: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && is_clear && !ovf_rise) |=> response == 8'h00)
        else $error("clear did not zero response");
    a_count_step: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && is_run && !has_error && !invalid_setting && !ovf_rise)
        |=> response == $past(count_up))
        else $error("counter did not step");
    a_run_loops: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && cmd == scm_pkg::BOTH_LOOP_RUN_CMD && !invalid_setting)
        |=> prox_loop_on && ambient_loop_on)
        else $error("loops not started");
    a_halt_loops: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && cmd == scm_pkg::BOTH_LOOP_HALT_CMD && !invalid_setting)
        |=> !prox_loop_on && !ambient_loop_on)
        else $error("loops not halted");
    a_shot_pulse: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && cmd == scm_pkg::BOTH_SINGLE_SHOT_CMD && !invalid_setting)
        |=> prox_shot && ambient_shot)
        else $error("single shot not started");
    a_wake_only: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_SLEEP && !cmd_write) |=> !awake)
        else $error("woke without command");
    a_invalid_code: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && invalid_setting && !has_error && !is_clear && !is_reset && !ovf_rise)
        |=> response == scm_pkg::INVALID_SETTING_CODE)
        else $error("invalid setting not reported");
    a_overflow_wins: assert property (@(posedge clk) disable iff (reset)
        (clk_en && ovf_rise && !has_error) |=> response == $past(ovf_code))
        else $error("overflow code not latched");
    a_reset_cmd: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_EXEC && is_reset)
        |=> !prox_loop_on && !ambient_loop_on && slave_address == scm_pkg::SLAVE_ADDR_RESET)
        else $error("reset command did not restore state");
    a_shot_busy: assert property (@(posedge clk) disable iff (reset)
        (clk_en && state == SCM_WAIT_MEAS) |-> chip_state_value == scm_pkg::CHIP_STATE_BUSY)
        else $error("chip not busy during single shot");
endmodule : scm_mailbox

// *** test/scm_host_model.sv ***
`timescale 1ns/1ps
// Host side of the command mailbox: it sends one command at a time.
module scm_host_model (
    input  wire logic       clk,
    input  wire logic       awake,
    output logic            cmd_write,
    output logic      [7:0] cmd_code
);
    initial begin
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
    end
    // The host waits until the engine sleeps again, because a write to a busy engine is lost.
    task automatic send(input logic [7:0] code);
        // A hang here is left to the bench watchdog, which fails the run.
        while (awake !== 1'b0) begin
            @(posedge clk);
            #1;
        end
        cmd_code  = code;
        cmd_write = 1'b1;
        @(posedge clk);
        #1;
        cmd_write = 1'b0;
        cmd_code  = ~code; // An inverted code after the strobe, so nothing leans on it.
    endtask : send
endmodule : scm_host_model

// *** test/scm_mailbox_test.sv ***
`timescale 1ns/1ps
// Drives the mailbox through the host model and checks its outputs.
module scm_mailbox_test;
    typedef struct packed {logic [7:0] code, wmb, rd, resp; logic [6:0] addr; logic [1:0] loops;} scm_row_t;
    logic       clk = 1'b0;
    logic       reset, clk_en, cmd_write, meas_done, overflow_pin, invalid_setting;
    logic       prox_loop_on, ambient_loop_on, prox_shot, ambient_shot, awake, seen_p, seen_a;
    logic [7:0] cmd_code, wmb, response, rd, chip_state, irq_state;
    logic [6:0] addr;
    logic [2:0] overflow_chan;
    int         n_errors = 0;
    int         checked = 0;
    scm_row_t   rows [14];
    logic [2:0] chans [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    always #2.5 clk = ~clk;
    scm_host_model i_scm_host_model (.clk(clk), .awake(awake), .cmd_write(cmd_write), .cmd_code(cmd_code));
    scm_mailbox i_scm_mailbox (.clk(clk), .reset(reset), .clk_en(clk_en), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .param_write_mailbox(wmb), .meas_done(meas_done), .overflow_pin(overflow_pin),
        .overflow_chan(overflow_chan), .invalid_setting(invalid_setting), .response(response),
        .param_read_mailbox(rd), .slave_address(addr), .prox_loop_on(prox_loop_on),
        .ambient_loop_on(ambient_loop_on), .prox_shot(prox_shot), .ambient_shot(ambient_shot), .awake(awake),
        .chip_state_value(chip_state), .interrupt_status_value(irq_state));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic run(input logic [7:0] code);
        i_scm_host_model.send(code);
        step(2);
    endtask : run
    task automatic test_done;
        $display("counts: %0d checked, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // A hang is cut short at 12000 cycles, well past the few hundred cycles that the tests need.
    initial begin
        #60000;
        n_errors++;
        test_done();
    end
    initial begin
        rows = '{'{8'ha3, 8'h5c, 8'h5c, 8'h01, 7'h5a, 2'h0}, '{8'he3, 8'h03, 8'h5f, 8'h02, 7'h5a, 2'h0},
                 '{8'hc3, 8'h0f, 8'h0f, 8'h03, 7'h5a, 2'h0}, '{8'h83, 8'hff, 8'h0f, 8'h04, 7'h5a, 2'h0},
                 '{8'h03, 8'h00, 8'h0f, 8'h05, 7'h5a, 2'h0}, '{8'h02, 8'h21, 8'h0f, 8'h06, 7'h21, 2'h0},
                 '{8'h0d, 8'h00, 8'h0f, 8'h07, 7'h21, 2'h2}, '{8'h0e, 8'h00, 8'h0f, 8'h08, 7'h21, 2'h3},
                 '{8'h09, 8'h00, 8'h0f, 8'h09, 7'h21, 2'h1}, '{8'h0a, 8'h00, 8'h0f, 8'h0a, 7'h21, 2'h0},
                 '{8'h0f, 8'h00, 8'h0f, 8'h0b, 7'h21, 2'h3}, '{8'h0b, 8'h00, 8'h0f, 8'h0c, 7'h21, 2'h0},
                 '{8'h1f, 8'h00, 8'h0f, 8'h0d, 7'h21, 2'h0}, '{8'h00, 8'h00, 8'h0f, 8'h00, 7'h21, 2'h0}};
        {reset, clk_en, meas_done, overflow_pin, overflow_chan, invalid_setting, wmb} = {2'b11, 14'h0};
        step(3);
        reset = 1'b0;
        check("response", 8'h00, response);
        check("address", 8'h5a, {1'b0, addr});
        check("chip state", 8'h00, chip_state);
        $display("reset values done");
        // Each row: one command, the wake at cycle one, the results at cycle two.
        foreach (rows[i]) begin
            wmb = rows[i].wmb;
            i_scm_host_model.send(rows[i].code);
            check("busy state", 8'h02, chip_state);
            step(1);
            check("response", rows[i].resp, response);
            check("read mailbox", rows[i].rd, rd);
            check("address", {1'b0, rows[i].addr}, {1'b0, addr});
            check("loops", {6'h0, rows[i].loops}, {6'h0, prox_loop_on, ambient_loop_on});
            check("done state", 8'h01, chip_state);
        end
        $display("command table done");
        wmb = 8'h77;
        step(3);
        check("awake", 8'h00, {7'h0, awake});
        repeat (17) run(8'h04);
        check("counter wrap", 8'h01, response);
        invalid_setting = 1'b1;
        run(8'h0d);
        invalid_setting = 1'b0;
        check("invalid", 8'h80, response);
        run(8'h03);
        check("sticky error", 8'h80, response);
        run(8'h00);
        check("cleared", 8'h00, response);
        $display("error codes done");
        // The overflow pin is asynchronous, so its edges fall between clock edges.
        foreach (chans[i]) begin
            overflow_chan = chans[i];
            #62.5 overflow_pin = 1'b1;
            #62.5 step(1);
            check("overflow", 8'h88 + {5'h0, chans[i]}, response);
            overflow_pin = 1'b0;
            #62.5 step(1);
            run(8'h00);
        end
        $display("overflow codes done");
        i_scm_host_model.send(8'h07);
        {seen_p, seen_a} = 2'b00;
        repeat (4) begin
            seen_p |= prox_shot;
            seen_a |= ambient_shot;
            step(1);
        end
        check("shot wait", 8'h01, {7'h0, awake});
        check("shot busy", 8'h02, chip_state);
        check("shots", 8'h03, {6'h0, seen_p, seen_a});
        meas_done = 1'b1;
        step(1);
        meas_done = 1'b0;
        step(3);
        check("shot response", 8'h01, response);
        check("irq state", 8'h01, irq_state);
        check("shot done state", 8'h01, chip_state);
        $display("single shot done");
        // With the enable low even a clean command strobe must leave every register alone.
        clk_en = 1'b0;
        i_scm_host_model.send(8'h0d);
        step(2);
        check("frozen response", 8'h01, response);
        check("frozen loops", 8'h00, {6'h0, prox_loop_on, ambient_loop_on});
        check("frozen awake", 8'h00, {7'h0, awake});
        clk_en = 1'b1;
        $display("clock enable done");
        run(8'h0f);
        run(8'h01);
        check("reset response", 8'h00, response);
        check("reset loops", 8'h00, {6'h0, prox_loop_on, ambient_loop_on});
        check("reset address", 8'h5a, {1'b0, addr});
        $display("soft reset done");
        // A second hardware reset mid-run; a command follows at the very first edge after it.
        reset = 1'b1;
        step(1);
        reset = 1'b0;
        check("reset chip state", 8'h00, chip_state);
        run(8'h04);
        check("count after reset", 8'h01, response);
        $display("hardware reset done");
        test_done();
    end
endmodule : scm_mailbox_test
